// ---- inc/buck_ctrl_pkg.sv ----
// Package for the buck switching and protection controller.
package buck_ctrl_pkg;

  // Register byte offsets
  localparam logic [11:0] OFF_CTRL = 12'h000;
  localparam logic [11:0] OFF_STATUS = 12'h004;
  localparam logic [11:0] OFF_IRQ_STAT = 12'h008;
  localparam logic [11:0] OFF_IRQ_MASK = 12'h00C;
  localparam logic [11:0] OFF_OVL_CNT = 12'h010;

  // Control register fields
  localparam int CTRL_SKIP_EN_BIT = 0;
  localparam int CTRL_HICCUP_EN_BIT = 1;
  localparam logic [1:0] CTRL_RESET = 2'h3;

  // Interrupt event bit positions
  localparam int EV_HS_LIMIT = 0;
  localparam int EV_SRC_LIMIT = 1;
  localparam int EV_SINK_LIMIT = 2;
  localparam int EV_HICCUP = 3;
  localparam int EV_THERMAL = 4;
  localparam int EV_BOOT_UV = 5;
  localparam int EV_W = 6;
  localparam logic [EV_W-1:0] MASK_RESET = 6'h00;

  // Cycle counts
  localparam int OVL_LIMIT = 256;
  localparam int HICCUP_CYCLES = 8192;
  localparam int OVL_W = 9;
  localparam int HIC_W = 14;

  // Controller states
  typedef enum logic [2:0] {
    ST_OFF,
    ST_RUN,
    ST_HICCUP,
    ST_THERMAL
  } ctrl_state_e;

  // Comparator results from the analog front end
  typedef struct packed {
    logic peak_hit;        // Peak switch current reached reference
    logic src_over;        // Low-side sourcing current above limit
    logic sink_over;       // Low-side sinking current above limit
    logic comp_above_clamp;// error_amp_level above skip_clamp_level
    logic skip_exit_cur;   // Peak inductor current above skip exit level
    logic boot_uv;         // gate_boost_node to switch_node below UVLO
    logic therm_trip;      // Junction above trip temperature
    logic therm_ok;        // Die below release temperature
    logic overload;        // Overload indication from error_amp_level
  } sense_s;

  // Gate drive commands
  typedef struct packed {
    logic hs_on;
    logic ls_on;
  } gate_s;

endpackage

// ---- logic/buck_switch_protection_ctrl.sv ----
// Switching-cycle control and protection sequencer with APB registers.
//
// The APB register port and the register addresses were decided locally.
`timescale 1ns/1ps

// What this block does
// R01 - High side off at peak current reference
// R02 - High side off pairs with low side on
// R03 - Sourcing over limit forces low side next cycle
// R04 - High side returns when sourcing below limit
// R05 - Sinking over limit: both off rest of cycle
// R06 - Over 256 overload cycles enters hiccup
// R07 - Hiccup waits 8192 cycles then restarts
// R08 - Allow 100% duty while bootstrap healthy
// R09 - Bootstrap undervoltage: high off, low on
// R10 - Thermal trip stops all switching
// R11 - Thermal release restarts power-up automatically
// R12 - Below clamp enters skipping, stops high side
// R13 - Skipping resumes above clamp, suspends below
// R14 - Skipping exits on current and clamp
// R15 - Enable low stops switching, high starts
// R16 - Cycle starts on sync falling edge
// R17 - Overload counter clears on clean cycle
module buck_switch_protection_ctrl
  import buck_ctrl_pkg::*;
(
  // Clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // APB slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // Converter inputs
  input wire logic enable_in,
  input wire logic sync_clk,
  input wire sense_s sense,
  // Gate drive and status
  output gate_s gate,
  output logic light_load_skipping,
  output logic irq
);

  ctrl_state_e state;          // Sequencer state
  logic sync_prev;             // Sync level last cycle
  logic cycle_start;           // Start of a switching cycle
  logic [OVL_W-1:0] ovl_cnt;   // Overloaded cycle count
  logic [HIC_W-1:0] hic_cnt;   // Hiccup wait count
  logic cycle_ovl;             // Overload seen in current cycle
  logic force_ls;              // Low side forced for this cycle
  logic sink_block;            // Both off for rest of cycle
  logic hs_done;               // High side ended this cycle
  logic [1:0] ctrl;            // Control register
  logic [EV_W-1:0] irq_stat;   // Sticky event bits
  logic [EV_W-1:0] irq_mask;   // Interrupt enables
  logic [EV_W-1:0] events;     // Event pulses this cycle
  logic wr_en;                 // APB write strobe
  logic hiccup_go;             // Overload limit crossed
  gate_s next_gate;            // Combinational gate decision

  // Cycle start on falling edge of the switching clock
  assign cycle_start = sync_prev & ~sync_clk; // see R16

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sync_prev <= 1'b0;
    end else begin
      sync_prev <= sync_clk;
    end
  end

  // Overload beyond limit starts hiccup when enabled
  assign hiccup_go = ctrl[CTRL_HICCUP_EN_BIT] && cycle_start &&
                     (cycle_ovl || sense.overload) &&
                     (ovl_cnt == OVL_W'(OVL_LIMIT)); // see R06

  // Sequencer: enable, hiccup, thermal
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state <= ST_OFF;
    end else begin
      case (state)
        ST_OFF: begin
          // Start while enable is high and no thermal trip
          if (enable_in && !sense.therm_trip) begin
            state <= ST_RUN; // see R15
          end
        end
        ST_RUN: begin
          if (sense.therm_trip) begin
            state <= ST_THERMAL; // see R10
          end else if (!enable_in) begin
            state <= ST_OFF; // see R15
          end else if (hiccup_go) begin
            state <= ST_HICCUP; // see R06
          end
        end
        ST_HICCUP: begin
          if (sense.therm_trip) begin
            state <= ST_THERMAL;
          end else if (!enable_in) begin
            state <= ST_OFF;
          end else if (cycle_start && hic_cnt == HIC_W'(HICCUP_CYCLES - 1)) begin
            state <= ST_RUN; // see R07
          end
        end
        ST_THERMAL: begin
          // Full power-up from the off state on release
          if (sense.therm_ok && !sense.therm_trip) begin
            state <= ST_OFF; // see R11
          end
        end
        default: begin
          state <= ST_OFF;
        end
      endcase
    end
  end

  // Hiccup wait counter in switching cycles
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      hic_cnt <= '0;
    end else if (state != ST_HICCUP) begin
      hic_cnt <= '0;
    end else if (cycle_start) begin
      hic_cnt <= hic_cnt + HIC_W'(1); // see R07
    end
  end

  // Overload cycle counter, cleared on a clean cycle
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ovl_cnt <= '0;
      cycle_ovl <= 1'b0;
    end else if (state != ST_RUN) begin
      ovl_cnt <= '0;
      cycle_ovl <= 1'b0;
    end else if (cycle_start) begin
      cycle_ovl <= sense.overload;
      if (cycle_ovl || sense.overload) begin
        if (ovl_cnt != OVL_W'(OVL_LIMIT)) begin
          ovl_cnt <= ovl_cnt + OVL_W'(1); // see R06
        end
      end else begin
        ovl_cnt <= '0; // see R17
      end
    end else if (sense.overload) begin
      cycle_ovl <= 1'b1;
    end
  end

  // Pulse-skip mode tracking
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      light_load_skipping <= 1'b0;
    end else if (state != ST_RUN || !ctrl[CTRL_SKIP_EN_BIT]) begin
      light_load_skipping <= 1'b0;
    end else if (!light_load_skipping && !sense.comp_above_clamp) begin
      light_load_skipping <= 1'b1; // see R12
    end else if (light_load_skipping && sense.comp_above_clamp &&
                 sense.skip_exit_cur) begin
      light_load_skipping <= 1'b0; // see R14
    end
  end

  // Per-cycle limit flags
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      force_ls <= 1'b0;
      sink_block <= 1'b0;
      hs_done <= 1'b0;
    end else if (cycle_start) begin
      // Sourcing limit sampled at cycle end, current level checked at start
      force_ls <= sense.src_over; // see R03
      sink_block <= 1'b0;
      hs_done <= 1'b0;
    end else begin
      if (sense.sink_over && gate.ls_on) begin
        sink_block <= 1'b1; // see R05
      end
      if (sense.peak_hit || sense.boot_uv) begin
        hs_done <= 1'b1; // see R01
      end
    end
  end

  // Gate decision
  always_comb begin
    next_gate = '0;
    if (state == ST_RUN) begin
      if (sink_block || (sense.sink_over && gate.ls_on)) begin
        next_gate = '0; // see R05
      end else if (force_ls) begin
        next_gate.ls_on = 1'b1; // see R03 R04
      end else if (sense.boot_uv) begin
        next_gate.ls_on = 1'b1; // see R09
      end else if (light_load_skipping && !sense.comp_above_clamp) begin
        next_gate = '0; // see R12 R13
      end else if (hs_done || sense.peak_hit) begin
        next_gate.ls_on = 1'b1; // see R01 R02
      end else begin
        // High side may stay on through cycle starts while boot is fine
        next_gate.hs_on = 1'b1; // see R08
      end
    end
  end

  // Registered gate outputs
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      gate <= '0;
    end else begin
      gate <= next_gate; // see R10 R15
    end
  end

  // Event pulses for the interrupt status
  always_comb begin
    events = '0;
    events[EV_HS_LIMIT] = state == ST_RUN && sense.peak_hit && gate.hs_on;
    events[EV_SRC_LIMIT] = cycle_start && sense.src_over && state == ST_RUN;
    events[EV_SINK_LIMIT] = sense.sink_over && gate.ls_on;
    events[EV_HICCUP] = state == ST_RUN && hiccup_go;
    events[EV_THERMAL] = state != ST_THERMAL && sense.therm_trip;
    events[EV_BOOT_UV] = gate.hs_on && sense.boot_uv;
  end

  assign wr_en = psel && penable && pwrite;

  // Control and mask registers
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctrl <= CTRL_RESET;
      irq_mask <= MASK_RESET;
    end else if (wr_en) begin
      if (paddr == OFF_CTRL) begin
        ctrl <= pwdata[1:0];
      end
      if (paddr == OFF_IRQ_MASK) begin
        irq_mask <= pwdata[EV_W-1:0];
      end
    end
  end

  // Sticky status, write one to clear; a new event wins
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      irq_stat <= '0;
    end else if (wr_en && paddr == OFF_IRQ_STAT) begin
      irq_stat <= (irq_stat & ~pwdata[EV_W-1:0]) | events;
    end else begin
      irq_stat <= irq_stat | events;
    end
  end

  assign irq = |(irq_stat & irq_mask);
  assign pready = 1'b1;

  // Unmapped addresses answer with an error
  always_comb begin
    pslverr = 1'b0;
    if (psel && penable) begin
      pslverr = !(paddr == OFF_CTRL || paddr == OFF_STATUS ||
                  paddr == OFF_IRQ_STAT || paddr == OFF_IRQ_MASK ||
                  paddr == OFF_OVL_CNT);
    end
  end

  // Read data registered in the setup cycle
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata <= '0;
    end else if (psel && !penable && !pwrite) begin
      case (paddr)
        OFF_CTRL: prdata <= {30'h0, ctrl};
        OFF_STATUS: prdata <= {25'h0, light_load_skipping, gate.hs_on, gate.ls_on,
                               1'b0, state};
        OFF_IRQ_STAT: prdata <= {26'h0, irq_stat};
        OFF_IRQ_MASK: prdata <= {26'h0, irq_mask};
        OFF_OVL_CNT: prdata <= {23'h0, ovl_cnt};
        default: prdata <= 32'h0;
      endcase
    end
  end

  // Checks
  AST_GATES_EXCLUSIVE: assert property (@(posedge pclk) disable iff (!presetn)
    !(gate.hs_on && gate.ls_on)) else $error("both gates on"); // see R02
  AST_PEAK_HS_OFF: assert property (@(posedge pclk) disable iff (!presetn)
    sense.peak_hit && !cycle_start |=> !gate.hs_on) else $error("hs stayed on"); // see R01
  AST_SRC_FORCE: assert property (@(posedge pclk) disable iff (!presetn)
    cycle_start && sense.src_over && state == ST_RUN && !sense.sink_over
    && !sense.therm_trip && enable_in && !hiccup_go |=> ##1 !gate.hs_on)
    else $error("src limit ignored"); // see R03
  AST_SINK_OFF: assert property (@(posedge pclk) disable iff (!presetn)
    sense.sink_over && gate.ls_on |=> !gate.ls_on && !gate.hs_on)
    else $error("sink limit ignored"); // see R05
  AST_THERM_STOP: assert property (@(posedge pclk) disable iff (!presetn)
    sense.therm_trip |=> ##1 gate == '0) else $error("switching in thermal"); // see R10
  AST_BOOT_UV: assert property (@(posedge pclk) disable iff (!presetn)
    state == ST_RUN && sense.boot_uv |=> !gate.hs_on) else $error("boot uv hs on"); // see R09
  AST_HICCUP_ENTRY: assert property (@(posedge pclk) disable iff (!presetn)
    state == ST_RUN && hiccup_go && !sense.therm_trip && enable_in |=> state == ST_HICCUP)
    else $error("no hiccup"); // see R06
  AST_EN_OFF: assert property (@(posedge pclk) disable iff (!presetn)
    !enable_in && state != ST_THERMAL |=> state == ST_OFF || state == ST_THERMAL)
    else $error("enable ignored"); // see R15
  AST_OVL_CLEAR: assert property (@(posedge pclk) disable iff (!presetn)
    state == ST_RUN && cycle_start && !cycle_ovl && !sense.overload |=> ovl_cnt == '0)
    else $error("overload count kept"); // see R17

  COV_HICCUP: cover property (@(posedge pclk) disable iff (!presetn)
    state == ST_HICCUP ##1 state == ST_RUN);
  COV_THERMAL: cover property (@(posedge pclk) disable iff (!presetn)
    state == ST_THERMAL ##1 state == ST_OFF);
  COV_SKIP: cover property (@(posedge pclk) disable iff (!presetn)
    light_load_skipping ##1 !light_load_skipping);
  COV_IRQ: cover property (@(posedge pclk) disable iff (!presetn) irq);

endmodule

// ---- verif/power_stage_model.sv ----
// Behavioural power stage and current comparators facing the controller.
`timescale 1ns/1ps
module power_stage_model
  import buck_ctrl_pkg::*;
(
  // Clock
  input wire logic pclk,
  // Gate commands, forced comparator levels and ramp length
  input wire gate_s gate,
  input wire sense_s forced,
  input wire logic [3:0] ramp,
  // Comparator results
  output sense_s sense
);
  logic [3:0] on_cnt = 4'h0; // Cycles the high side has conducted
  // Inductor current ramps while the high side conducts, resets when it stops
  always_ff @(posedge pclk) begin
    if (!gate.hs_on) begin
      on_cnt <= 4'h0;
    end else if (on_cnt != 4'hF) begin
      on_cnt <= on_cnt + 4'h1;
    end
  end
  // Peak comparator trips once the ramp length is reached; other levels forced
  always_comb begin
    sense = forced;
    sense.peak_hit = forced.peak_hit | (gate.hs_on && on_cnt >= ramp);
  end
endmodule

// ---- verif/tb_top.sv ----
// Self-checking bench for the buck switching and protection controller.
`timescale 1ns/1ps
`define CHK(nm, ex, got) begin total_checks++; if ((got) !== (ex)) begin miscompares++; \
  $display("BAD %s expected %0h seen %0h", nm, ex, got); end end
module tb_top
  import buck_ctrl_pkg::*;
;
  // Bus, converter and bench signals
  logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0, prdata, rd;
  logic pready, pslverr, err, skipping, irq, hs_seen, enable_in = 0, sync_clk = 0, sync_run = 1;
  logic [1:0] sdiv = 2'h0;
  logic [3:0] ramp = 4'h2;
  sense_s forced = 9'h022;
  sense_s sense;
  gate_s gate;
  int miscompares = 0, total_checks = 0, cycles = 0, exp_stat = 0, n;
  buck_switch_protection_ctrl dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .enable_in(enable_in), .sync_clk(sync_clk), .sense(sense), .gate(gate),
    .light_load_skipping(skipping), .irq(irq));
  power_stage_model stage (.pclk(pclk), .gate(gate), .forced(forced), .ramp(ramp), .sense(sense));
  // 40 MHz clock
  initial forever #12.5 pclk = ~pclk;
  // Switching clock at a quarter of pclk, held low while frozen
  always @(posedge pclk) begin
    sdiv <= sdiv + 2'h1;
    sync_clk <= sync_run & sdiv[1];
    cycles++;
    if (cycles == 60000) begin
      miscompares++;
      print_verdict();
    end
  end
  task automatic print_verdict();
    $display("checks %0d miscompares %0d", total_checks, miscompares);
    if (miscompares == 0 && total_checks > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask
  // One APB transfer: setup, then access until pready
  task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    // Wait for pready; only the bench timeout ends a hung transfer
    do begin
      @(posedge pclk);
    end while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic rdchk(input string nm, input logic [11:0] a, input logic [31:0] m,
                       input logic [31:0] ex);
    apb(1'b0, a, 32'h0);
    `CHK(nm, ex, rd & m)
  endtask
  // Wait, bounded, for the high side to conduct
  task automatic wait_hs();
    n = 0;
    while (gate.hs_on !== 1'b1 && n < 80) begin
      @(posedge pclk);
      n++;
    end
  endtask
  // Note any high-side conduction over k cycles
  task automatic watch(input int k);
    hs_seen = 1'b0;
    repeat (k) begin
      @(posedge pclk);
      hs_seen = hs_seen | gate.hs_on;
    end
  endtask
  initial begin
    n = $urandom(32'h6CE81DBF);
    ramp = 4'h1 + 4'($urandom % 4);
    repeat (4) @(posedge pclk);
    presetn <= 1'b1;
    rdchk("ctrl", OFF_CTRL, 32'hFFFFFFFF, 32'h3);
    rdchk("mask", OFF_IRQ_MASK, 32'hFFFFFFFF, 32'h0);
    apb(1'b0, 12'h0FC, 32'h0);
    `CHK("slverr", 1'b1, err)
    enable_in <= 1'b1;
    wait_hs();
    `CHK("hs_start", 1'b1, gate.hs_on)
    // Freeze cycles so a peak hit is the only cause of the turn-off
    sync_run <= 1'b0;
    n = 0;
    do begin
      @(posedge pclk);
      n++;
    end while (sense.peak_hit !== 1'b1 && n < 20);
    #1;
    `CHK("peak_gate", 2'b01, gate)
    exp_stat = exp_stat | (1 << EV_HS_LIMIT);
    `CHK("irq_masked", 1'b0, irq)
    apb(1'b1, OFF_IRQ_MASK, 32'h1);
    #1;
    `CHK("irq_on", 1'b1, irq)
    rdchk("stat", OFF_IRQ_STAT, 32'h1, exp_stat[31:0]);
    apb(1'b1, OFF_IRQ_STAT, 32'h1);
    exp_stat = exp_stat & ~(1 << EV_HS_LIMIT);
    #1;
    `CHK("irq_clr", 1'b0, irq)
    @(posedge pclk);
    forced.sink_over <= 1'b1;
    repeat (2) @(posedge pclk);
    #1;
    `CHK("sink_gate", 2'b00, gate)
    exp_stat = exp_stat | (1 << EV_SINK_LIMIT);
    @(posedge pclk);
    forced.sink_over <= 1'b0;
    forced.src_over <= 1'b1;
    sync_run <= 1'b1;
    watch(4);
    watch(24);
    `CHK("src_hs", 1'b0, hs_seen)
    `CHK("src_ls", 1'b1, gate.ls_on)
    exp_stat = exp_stat | (1 << EV_SRC_LIMIT);
    forced.src_over <= 1'b0;
    wait_hs();
    `CHK("src_back", 1'b1, gate.hs_on)
    forced.therm_trip <= 1'b1;
    forced.therm_ok <= 1'b0;
    // Gates fall one edge after the state change, so let that edge pass
    @(posedge pclk);
    rdchk("therm", OFF_STATUS, 32'h37, 32'h3);
    exp_stat = exp_stat | (1 << EV_THERMAL);
    forced.therm_trip <= 1'b0;
    forced.therm_ok <= 1'b1;
    wait_hs();
    `CHK("therm_back", 1'b1, gate.hs_on)
    forced.comp_above_clamp <= 1'b0;
    watch(16);
    watch(16);
    `CHK("skip_on", 1'b1, skipping)
    `CHK("skip_hs", 1'b0, hs_seen)
    forced.comp_above_clamp <= 1'b1;
    watch(16);
    `CHK("skip_hold", 1'b1, skipping)
    `CHK("skip_resume", 1'b1, hs_seen)
    forced.skip_exit_cur <= 1'b1;
    watch(24);
    `CHK("skip_off", 1'b0, skipping)
    forced.overload <= 1'b1;
    repeat (800) @(posedge pclk);
    rdchk("ovl_run", OFF_STATUS, 32'h7, 32'h1);
    exp_stat = exp_stat | (1 << EV_HS_LIMIT);
    repeat (400) @(posedge pclk);
    rdchk("hiccup", OFF_STATUS, 32'h7, 32'h2);
    rdchk("hic_irq", OFF_IRQ_STAT, 32'h8, 32'h8);
    exp_stat = exp_stat | (1 << EV_HICCUP);
    forced.overload <= 1'b0;
    repeat (32000) @(posedge pclk);
    rdchk("hic_hold", OFF_STATUS, 32'h7, 32'h2);
    repeat (1000) @(posedge pclk);
    rdchk("hic_end", OFF_STATUS, 32'h7, 32'h1);
    // Both control features off: no skipping, no hiccup, counter saturates
    apb(1'b1, OFF_CTRL, 32'h0);
    rdchk("ctrl_wr", OFF_CTRL, 32'h3, 32'h0);
    forced.comp_above_clamp <= 1'b0;
    forced.overload <= 1'b1;
    repeat (1100) @(posedge pclk);
    watch(16);
    `CHK("skip_dis", 1'b0, skipping)
    `CHK("skip_dis_hs", 1'b1, hs_seen)
    rdchk("no_hiccup", OFF_STATUS, 32'h7, 32'h1);
    rdchk("ovl_sat", OFF_OVL_CNT, 32'h1FF, OVL_LIMIT);
    forced.overload <= 1'b0;
    forced.comp_above_clamp <= 1'b1;
    repeat (16) @(posedge pclk);
    rdchk("ovl_clr", OFF_OVL_CNT, 32'h1FF, 32'h0);
    apb(1'b1, OFF_CTRL, 32'h3);
    // Enable low stops switching, high restarts it
    enable_in <= 1'b0;
    watch(4);
    watch(8);
    `CHK("en_off_hs", 1'b0, hs_seen)
    rdchk("en_off", OFF_STATUS, 32'h37, 32'h0);
    enable_in <= 1'b1;
    wait_hs();
    `CHK("en_back", 1'b1, gate.hs_on)
    // Long ramp, then bootstrap undervoltage early in a conduction phase
    ramp <= 4'hF;
    n = 0;
    while (gate.hs_on !== 1'b0 && n < 80) begin
      @(posedge pclk);
      n++;
    end
    wait_hs();
    forced.boot_uv <= 1'b1;
    watch(1);
    watch(8);
    `CHK("boot_hs", 1'b0, hs_seen)
    `CHK("boot_ls", 1'b1, gate.ls_on)
    exp_stat = exp_stat | (1 << EV_BOOT_UV);
    forced.boot_uv <= 1'b0;
    wait_hs();
    `CHK("boot_back", 1'b1, gate.hs_on)
    rdchk("stat_all", OFF_IRQ_STAT, 32'h3F, exp_stat[31:0]);
    print_verdict();
  end
endmodule
